/* File: shared/mid_pkg.sv */
// Types and constants shared by the instruction decoder and its bench.
// Assumes one core clock where each clock edge is one oscillator period.
package mid_pkg;

  // Word layout
  localparam int unsigned MID_IW = 14;
  localparam int unsigned MID_AW = 11;
  localparam int unsigned MID_CLS_HI = 13;
  localparam int unsigned MID_CLS_LO = 12;
  localparam int unsigned MID_DEST_BIT = 7;
  localparam int unsigned MID_BPOS_LO = 7;

  // Timing: oscillator periods in one instruction cycle, and the reference rate
  localparam int unsigned MID_OSC_PER_CYCLE = 4;
  localparam int unsigned MID_REF_OSC_MHZ = 4;
  localparam int unsigned MID_REF_CYCLE_NS = MID_OSC_PER_CYCLE * 1000 / MID_REF_OSC_MHZ;

  // Reset values
  localparam logic [MID_AW-1:0] MID_RST_PC = 11'h000;
  localparam logic [7:0] MID_RST_ACCUM = 8'h00;
  localparam logic MID_RST_WDT_FLAG = 1'b1;
  localparam logic MID_RST_SLEEP_FLAG = 1'b1;

  // Fixed control words of the zero opcode group
  localparam logic [7:0] MID_LO_RETURN = 8'h08;
  localparam logic [7:0] MID_LO_RETIRQ = 8'h09;
  localparam logic [7:0] MID_LO_WDT = 8'h64;
  localparam logic [7:0] MID_LO_SLEEP = 8'h63;

  // Quarter phases of one instruction cycle, Gray sequence
  typedef enum logic [1:0] {
    MID_Q1 = 2'b00,
    MID_Q2 = 2'b01,
    MID_Q3 = 2'b11,
    MID_Q4 = 2'b10
  } mid_phase_t;

  typedef enum logic [5:0] {
    MID_IDLE_OP, MID_ADD_ACCUM_TO_REG, MID_AND_ACCUM_WITH_REG, MID_ZERO_REG, MID_ZERO_ACCUM,
    MID_INVERT_REG, MID_DECREMENT_REG, MID_DECREMENT_SKIP_ZERO, MID_INCREMENT_REG,
    MID_INCREMENT_SKIP_ZERO, MID_OR_ACCUM_WITH_REG, MID_MOVE_REG, MID_STORE_ACCUM,
    MID_ROTATE_LEFT_CARRY, MID_ROTATE_RIGHT_CARRY, MID_SUB_ACCUM_FROM_REG,
    MID_NIBBLE_EXCHANGE, MID_XOR_ACCUM_WITH_REG, MID_BIT_ZERO, MID_BIT_ONE,
    MID_TEST_SKIP_IF_ZERO, MID_TEST_SKIP_IF_ONE, MID_ADD_LITERAL, MID_AND_LITERAL,
    MID_CALL, MID_WATCHDOG_KICK, MID_JUMP_ABSOLUTE, MID_OR_LITERAL, MID_LOAD_LITERAL,
    MID_RETURN_FROM_IRQ, MID_RETURN_WITH_CONST, MID_RETURN, MID_STANDBY,
    MID_SUB_FROM_LITERAL, MID_XOR_LITERAL
  } mid_op_t;

  // Decoded instruction fields
  typedef struct packed {
    mid_op_t op;
    logic result_target;
    logic [6:0] register_index;
    logic [2:0] position_in_word;
    logic [7:0] literal8;
    logic [MID_AW-1:0] literal11;
  } mid_dec_t;

  // Status flags kept by the block
  typedef struct packed {
    logic overflow_out;
    logic nibble_overflow;
    logic result_null_flag;
    logic watchdog_expired_flag;
    logic sleep_entered_flag;
  } mid_flags_t;

  // Control outputs towards program memory, file registers and stack
  typedef struct packed {
    logic [MID_AW-1:0] fetch_pointer;
    logic [6:0] fr_raddr;
    logic [6:0] fr_waddr;
    logic [7:0] fr_wdata;
    logic fr_we;
    logic push;
    logic [MID_AW-1:0] push_addr;
    logic pop;
    logic irq_return;
    logic watchdog_kick;
    logic standby_enter;
    logic cycle_nop;
  } mid_ctl_t;

  // Adder result with both carries
  typedef struct packed {
    logic c;
    logic dc;
    logic [7:0] sum;
  } mid_add_t;

endpackage

/* File: hw/mid_decoder.sv */
// Instruction decoder and execution control for a 14-bit accumulator core.
// Assumes program memory, file registers and the stack sit on the same clock;
// instr_word, reg_rdata and stack_head are read at the last quarter phase.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Two top bits select the instruction class
// - Low seven bits address file registers
// - Bit 7 steers result to accumulator/register
// - Three bits above address pick bit
// - Don't-care bits never change decode
// - Skip or branch costs one nop cycle
// - Four oscillator periods per instruction cycle
// - Logic and move ops touch zero flag only
// - Add and subtract update carry, nibble, zero
// - Count-and-skip ops skip on zero, no flags
// - Rotates go through carry, change carry only
// - Bit ops clear, set, test-skip; no flags
// - Literal logic ops set zero; load none
// - Returns restore fetch pointer, two cycles
// - Call and jump use eleven-bit target
// - Watchdog kick and standby set status bits
// - Literal is eight or eleven bits
module mid_decoder
  import mid_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [MID_IW-1:0] instr_word,
  input wire logic [7:0] reg_rdata,
  input wire logic [MID_AW-1:0] stack_head,
  output var mid_ctl_t ctl,
  output var logic [7:0] accum,
  output var mid_flags_t flags
);

  typedef struct packed {
    mid_phase_t phase;
    logic [MID_IW-1:0] ir;
    logic discard;
    logic [7:0] accum;
    mid_flags_t flags;
    mid_ctl_t ctl;
  } mid_state_t;

  mid_state_t s_r;
  mid_state_t s_nxt;

  // Split a word into class, operation and operand fields
  function automatic mid_dec_t mid_decode(input logic [MID_IW-1:0] w);
    mid_dec_t d;
    d.op = MID_IDLE_OP;
    d.result_target = w[MID_DEST_BIT];
    d.register_index = w[6:0];
    d.position_in_word = w[MID_BPOS_LO+2:MID_BPOS_LO];
    d.literal8 = w[7:0];
    d.literal11 = w[MID_AW-1:0];
    unique case (w[MID_CLS_HI:MID_CLS_LO])
      2'b00: begin
        unique case (w[11:8])
          4'h0: begin
            if (w[7]) begin
              d.op = MID_STORE_ACCUM;
            end else if (w[7:0] == MID_LO_RETURN) begin
              d.op = MID_RETURN;
            end else if (w[7:0] == MID_LO_RETIRQ) begin
              d.op = MID_RETURN_FROM_IRQ;
            end else if (w[7:0] == MID_LO_WDT) begin
              d.op = MID_WATCHDOG_KICK;
            end else if (w[7:0] == MID_LO_SLEEP) begin
              d.op = MID_STANDBY;
            end else begin
              d.op = MID_IDLE_OP;
            end
          end
          4'h1: d.op = w[7] ? MID_ZERO_REG : MID_ZERO_ACCUM;
          4'h2: d.op = MID_SUB_ACCUM_FROM_REG;
          4'h3: d.op = MID_DECREMENT_REG;
          4'h4: d.op = MID_OR_ACCUM_WITH_REG;
          4'h5: d.op = MID_AND_ACCUM_WITH_REG;
          4'h6: d.op = MID_XOR_ACCUM_WITH_REG;
          4'h7: d.op = MID_ADD_ACCUM_TO_REG;
          4'h8: d.op = MID_MOVE_REG;
          4'h9: d.op = MID_INVERT_REG;
          4'ha: d.op = MID_INCREMENT_REG;
          4'hb: d.op = MID_DECREMENT_SKIP_ZERO;
          4'hc: d.op = MID_ROTATE_RIGHT_CARRY;
          4'hd: d.op = MID_ROTATE_LEFT_CARRY;
          4'he: d.op = MID_NIBBLE_EXCHANGE;
          4'hf: d.op = MID_INCREMENT_SKIP_ZERO;
        endcase
      end
      2'b01: begin
        unique case (w[11:10])
          2'b00: d.op = MID_BIT_ZERO;
          2'b01: d.op = MID_BIT_ONE;
          2'b10: d.op = MID_TEST_SKIP_IF_ZERO;
          2'b11: d.op = MID_TEST_SKIP_IF_ONE;
        endcase
      end
      2'b10: d.op = w[11] ? MID_JUMP_ABSOLUTE : MID_CALL;
      2'b11: begin
        // Don't-care bits of the literal group are simply not examined
        unique casez (w[11:8])
          4'b00??: d.op = MID_LOAD_LITERAL;
          4'b01??: d.op = MID_RETURN_WITH_CONST;
          4'b1000: d.op = MID_OR_LITERAL;
          4'b1001: d.op = MID_AND_LITERAL;
          4'b1010: d.op = MID_XOR_LITERAL;
          4'b1011: d.op = MID_IDLE_OP;
          4'b110?: d.op = MID_SUB_FROM_LITERAL;
          4'b111?: d.op = MID_ADD_LITERAL;
        endcase
      end
    endcase
    return d;
  endfunction

  // 8-bit add with carry in; subtraction passes the inverted accumulator and 1
  function automatic mid_add_t mid_add8(input logic [7:0] a, input logic [7:0] b,
                                        input logic cin);
    mid_add_t r;
    logic [4:0] lo;
    logic [8:0] full;
    lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    r.c = full[8];
    r.dc = lo[4];
    r.sum = full[7:0];
    return r;
  endfunction

  // Phase sequencing and instruction execution
  always_comb begin
    mid_dec_t d;
    mid_add_t ar;
    logic [7:0] res;
    logic [7:0] mask;
    logic wr_res;
    logic flush;
    s_nxt = s_r;
    d = mid_decode(s_r.ir);
    ar = '0;
    res = 8'h00;
    mask = 8'h01 << d.position_in_word;
    wr_res = 1'b0;
    flush = 1'b0;
    // Strobes live for one clock only
    s_nxt.ctl.fr_we = 1'b0;
    s_nxt.ctl.push = 1'b0;
    s_nxt.ctl.pop = 1'b0;
    s_nxt.ctl.irq_return = 1'b0;
    s_nxt.ctl.watchdog_kick = 1'b0;
    s_nxt.ctl.standby_enter = 1'b0;
    unique case (s_r.phase)
      MID_Q1: s_nxt.phase = MID_Q2;
      MID_Q2: s_nxt.phase = MID_Q3;
      MID_Q3: s_nxt.phase = MID_Q4;
      MID_Q4: begin
        s_nxt.phase = MID_Q1;
        // Prefetch of the next word overlaps execution of this one
        s_nxt.ir = instr_word;
        s_nxt.ctl.fr_raddr = instr_word[6:0];
        s_nxt.ctl.fetch_pointer = s_r.ctl.fetch_pointer + 11'h001;
        if (!s_r.discard) begin
          unique case (d.op)
            MID_ADD_ACCUM_TO_REG, MID_SUB_ACCUM_FROM_REG: begin
              ar = (d.op == MID_ADD_ACCUM_TO_REG) ? mid_add8(reg_rdata, s_r.accum, 1'b0)
                                                  : mid_add8(reg_rdata, ~s_r.accum, 1'b1);
              res = ar.sum;
              wr_res = 1'b1;
              s_nxt.flags.overflow_out = ar.c;
              s_nxt.flags.nibble_overflow = ar.dc;
              s_nxt.flags.result_null_flag = (ar.sum == 8'h00);
            end
            MID_AND_ACCUM_WITH_REG, MID_OR_ACCUM_WITH_REG, MID_XOR_ACCUM_WITH_REG,
            MID_INVERT_REG, MID_DECREMENT_REG, MID_INCREMENT_REG, MID_MOVE_REG: begin
              unique case (d.op)
                MID_AND_ACCUM_WITH_REG: res = reg_rdata & s_r.accum;
                MID_OR_ACCUM_WITH_REG: res = reg_rdata | s_r.accum;
                MID_XOR_ACCUM_WITH_REG: res = reg_rdata ^ s_r.accum;
                MID_INVERT_REG: res = ~reg_rdata;
                MID_DECREMENT_REG: res = reg_rdata - 8'h01;
                MID_INCREMENT_REG: res = reg_rdata + 8'h01;
                default: res = reg_rdata;
              endcase
              wr_res = 1'b1;
              s_nxt.flags.result_null_flag = (res == 8'h00);
            end
            MID_ZERO_REG: begin
              s_nxt.ctl.fr_we = 1'b1;
              s_nxt.ctl.fr_waddr = d.register_index;
              s_nxt.ctl.fr_wdata = 8'h00;
              s_nxt.flags.result_null_flag = 1'b1;
            end
            MID_ZERO_ACCUM: begin
              s_nxt.accum = 8'h00;
              s_nxt.flags.result_null_flag = 1'b1;
            end
            MID_DECREMENT_SKIP_ZERO, MID_INCREMENT_SKIP_ZERO: begin
              res = (d.op == MID_DECREMENT_SKIP_ZERO) ? reg_rdata - 8'h01 : reg_rdata + 8'h01;
              wr_res = 1'b1;
              flush = (res == 8'h00);
            end
            MID_ROTATE_LEFT_CARRY: begin
              res = {reg_rdata[6:0], s_r.flags.overflow_out};
              wr_res = 1'b1;
              s_nxt.flags.overflow_out = reg_rdata[7];
            end
            MID_ROTATE_RIGHT_CARRY: begin
              res = {s_r.flags.overflow_out, reg_rdata[7:1]};
              wr_res = 1'b1;
              s_nxt.flags.overflow_out = reg_rdata[0];
            end
            MID_NIBBLE_EXCHANGE: begin
              res = {reg_rdata[3:0], reg_rdata[7:4]};
              wr_res = 1'b1;
            end
            MID_STORE_ACCUM: begin
              s_nxt.ctl.fr_we = 1'b1;
              s_nxt.ctl.fr_waddr = d.register_index;
              s_nxt.ctl.fr_wdata = s_r.accum;
            end
            // Bit ops are read-modify-write of the whole register
            MID_BIT_ZERO, MID_BIT_ONE: begin
              s_nxt.ctl.fr_we = 1'b1;
              s_nxt.ctl.fr_waddr = d.register_index;
              s_nxt.ctl.fr_wdata = (d.op == MID_BIT_ONE) ? (reg_rdata | mask)
                                                         : (reg_rdata & ~mask);
            end
            MID_TEST_SKIP_IF_ZERO: flush = ((reg_rdata & mask) == 8'h00);
            MID_TEST_SKIP_IF_ONE: flush = ((reg_rdata & mask) != 8'h00);
            MID_ADD_LITERAL, MID_SUB_FROM_LITERAL: begin
              ar = (d.op == MID_ADD_LITERAL) ? mid_add8(d.literal8, s_r.accum, 1'b0)
                                             : mid_add8(d.literal8, ~s_r.accum, 1'b1);
              s_nxt.accum = ar.sum;
              s_nxt.flags.overflow_out = ar.c;
              s_nxt.flags.nibble_overflow = ar.dc;
              s_nxt.flags.result_null_flag = (ar.sum == 8'h00);
            end
            MID_AND_LITERAL, MID_OR_LITERAL, MID_XOR_LITERAL: begin
              unique case (d.op)
                MID_AND_LITERAL: res = s_r.accum & d.literal8;
                MID_OR_LITERAL: res = s_r.accum | d.literal8;
                default: res = s_r.accum ^ d.literal8;
              endcase
              s_nxt.accum = res;
              s_nxt.flags.result_null_flag = (res == 8'h00);
            end
            MID_LOAD_LITERAL: s_nxt.accum = d.literal8;
            MID_CALL, MID_JUMP_ABSOLUTE: begin
              // Return address is the word already being fetched
              s_nxt.ctl.push = (d.op == MID_CALL);
              s_nxt.ctl.push_addr = s_r.ctl.fetch_pointer;
              s_nxt.ctl.fetch_pointer = d.literal11;
              flush = 1'b1;
            end
            MID_RETURN, MID_RETURN_FROM_IRQ, MID_RETURN_WITH_CONST: begin
              s_nxt.ctl.pop = 1'b1;
              s_nxt.ctl.irq_return = (d.op == MID_RETURN_FROM_IRQ);
              if (d.op == MID_RETURN_WITH_CONST) begin
                s_nxt.accum = d.literal8;
              end
              s_nxt.ctl.fetch_pointer = stack_head;
              flush = 1'b1;
            end
            MID_WATCHDOG_KICK: begin
              s_nxt.ctl.watchdog_kick = 1'b1;
              s_nxt.flags.watchdog_expired_flag = 1'b1;
              s_nxt.flags.sleep_entered_flag = 1'b1;
            end
            MID_STANDBY: begin
              s_nxt.ctl.standby_enter = 1'b1;
              s_nxt.flags.watchdog_expired_flag = 1'b1;
              s_nxt.flags.sleep_entered_flag = 1'b0;
            end
            default: res = 8'h00;
          endcase
          // Route the result by the destination bit
          if (wr_res && d.result_target) begin
            s_nxt.ctl.fr_we = 1'b1;
            s_nxt.ctl.fr_waddr = d.register_index;
            s_nxt.ctl.fr_wdata = res;
          end else if (wr_res) begin
            s_nxt.accum = res;
          end
        end
        // The prefetched word becomes a dead cycle after skip or branch
        s_nxt.discard = flush;
        s_nxt.ctl.cycle_nop = flush;
      end
    endcase
  end

  // State register; the word held at reset is never executed, so the first cycle after reset is a no-op
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_r <= '0;
      s_r.phase <= MID_Q1;
      s_r.discard <= 1'b1;
      s_r.accum <= MID_RST_ACCUM;
      s_r.flags.watchdog_expired_flag <= MID_RST_WDT_FLAG;
      s_r.flags.sleep_entered_flag <= MID_RST_SLEEP_FLAG;
      s_r.ctl.fetch_pointer <= MID_RST_PC;
      s_r.ctl.cycle_nop <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign ctl = s_r.ctl;
  assign accum = s_r.accum;
  assign flags = s_r.flags;

endmodule
`default_nettype wire

/* File: verification/mid_decoder_sva.sv */
// Port-level checks of the instruction decoder.
// Assumes one clock; a word latched at a Q4 edge executes at the next Q4 edge.
`timescale 1ns/1ps
`default_nettype none
module mid_decoder_sva
  import mid_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [MID_IW-1:0] instr_word,
  input wire logic [7:0] reg_rdata,
  input wire logic [MID_AW-1:0] stack_head,
  input wire mid_ctl_t ctl,
  input wire logic [7:0] accum,
  input wire mid_flags_t flags
);
  logic [1:0] ph_r;
  logic [MID_IW-1:0] ir_r;
  logic q4;
  logic ex;
  logic ret;
  logic rot_c;
  logic [7:0] bit_new;
  // Shadow phase and executing word, rebuilt from reset
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ph_r <= 2'h0;
      ir_r <= 14'h0000;
    end else begin
      ph_r <= ph_r + 2'h1;
      if (q4) begin
        ir_r <= instr_word;
      end
    end
  end
  // A forced no-op cycle never counts as execution
  assign q4 = ph_r == 2'h3;
  assign ex = q4 && !ctl.cycle_nop;
  assign ret = ir_r == 14'h0008 || ir_r == 14'h0009 || ir_r[13:10] == 4'hd;
  assign rot_c = ir_r[8] ? reg_rdata[7] : reg_rdata[0];
  assign bit_new = ir_r[10] ? reg_rdata | (8'h01 << ir_r[9:7]) : reg_rdata & ~(8'h01 << ir_r[9:7]);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // Discarded slot: one full cycle of no-op, then real work again
  sequence nop_cycle;
    ctl.cycle_nop [*4] ##1 !ctl.cycle_nop;
  endsequence
  chk_fp_boundary: assert property ($changed(ctl.fetch_pointer) |-> $past(q4))
    else $error("fetch pointer moved inside a cycle");
  chk_branch_nop: assert property (ex && (ir_r[13:12] == 2'b10 || ret) |=> nop_cycle)
    else $error("branch not followed by one no-op cycle");
  chk_jump_target: assert property (ex && ir_r[13:12] == 2'b10 |=>
    ctl.fetch_pointer == $past(ir_r[10:0]) && ctl.push == !$past(ir_r[11]))
    else $error("wrong branch target or push");
  chk_ret_pop: assert property (ex && ret |=> ctl.pop && ctl.fetch_pointer == $past(stack_head))
    else $error("return did not restore from stack");
  chk_idle_write: assert property (!ex |=> !ctl.fr_we)
    else $error("write outside an executing cycle");
  chk_dest_write: assert property (ex && ir_r[13:12] == 2'b00 |=>
    ctl.fr_we == $past(ir_r[7]) && (!ctl.fr_we || ctl.fr_waddr == $past(ir_r[6:0])))
    else $error("byte op destination wrong");
  chk_quiet_flags: assert property (ex && (ir_r[13:12] == 2'b01 ||
    ir_r[13:11] == 3'b001 && ir_r[9:8] == 2'b11) |=> $stable(flags))
    else $error("flag changed by a flagless op");
  chk_rot_carry: assert property (ex && ir_r[13:9] == 5'b00110 |=>
    flags.overflow_out == $past(rot_c) && $stable(flags[3:0]))
    else $error("rotate carry wrong");
  chk_bit_write: assert property (ex && ir_r[13:11] == 3'b010 |=>
    ctl.fr_we && ctl.fr_wdata == $past(bit_new))
    else $error("bit op wrote wrong byte");
  chk_kick_flags: assert property (ex && ir_r == 14'h0064 |=>
    ctl.watchdog_kick && flags[1:0] == 2'b11)
    else $error("watchdog kick status wrong");
  chk_load_lit: assert property (ex && ir_r[13:10] == 4'hc |=>
    accum == $past(ir_r[7:0]) && $stable(flags))
    else $error("load literal wrong");
  chk_irq_ret: assert property (ex && ir_r == 14'h0009 |=> ctl.irq_return && ctl.pop)
    else $error("return from irq not flagged");
  chk_standby_flags: assert property (ex && ir_r == 14'h0063 |=>
    ctl.standby_enter && flags[1:0] == 2'b10)
    else $error("standby status wrong");
  // Stack and system strobes only ever follow a real execution edge
  chk_idle_strobes: assert property (!ex |=>
    !(ctl.push || ctl.pop || ctl.irq_return || ctl.watchdog_kick || ctl.standby_enter))
    else $error("strobe outside an executing cycle");
endmodule
bind mid_decoder mid_decoder_sva i_mid_decoder_sva (.clk(clk), .nrst(nrst), .instr_word(instr_word),
  .reg_rdata(reg_rdata), .stack_head(stack_head), .ctl(ctl), .accum(accum), .flags(flags));
`default_nettype wire

/* File: verification/mid_mem.sv */
// Program memory, file registers and return stack facing the decoder.
// Assumes the bench fills the arrays and clears the stack pointer in reset.
`timescale 1ns/1ps
`default_nettype none
module mid_mem
  import mid_pkg::*;
(
  input wire logic clk,
  input wire mid_ctl_t ctl,
  output logic [MID_IW-1:0] instr_word,
  output logic [7:0] reg_rdata,
  output logic [MID_AW-1:0] stack_head
);
  logic [MID_IW-1:0] prog [2048];
  logic [7:0] regs [128];
  logic [MID_AW-1:0] stk [8];
  logic [2:0] sp;
  // Plain reads, always driven; stack wraps at eight like a real one
  assign instr_word = prog[ctl.fetch_pointer];
  assign reg_rdata = regs[ctl.fr_raddr];
  assign stack_head = stk[sp - 3'h1];
  // Writes and stack moves follow the one-clock strobes
  always @(posedge clk) begin
    if (ctl.fr_we) regs[ctl.fr_waddr] <= ctl.fr_wdata;
    if (ctl.push) stk[sp] <= ctl.push_addr;
    if (ctl.push) sp <= sp + 3'h1;
    if (ctl.pop) sp <= sp - 3'h1;
  end
endmodule
`default_nettype wire

/* File: verification/tb_mid_decoder.sv */
// Self-checking bench: decoder against an instruction-level model.
// Assumes mid_mem as program side and the bound port checker.
`timescale 1ns/1ps
`default_nettype none
module tb_mid_decoder;
  import mid_pkg::*;
  localparam logic [15:0] ZMASK = 16'h07fe;
  // Tail calls into a plain return, then a return from irq that pops an empty stack
  localparam logic [13:0] DIR_PROG [17] = '{14'h330f, 14'h3ef1, 14'h00ff, 14'h0fff, 14'h0bff,
    14'h3fff, 14'h1bff, 14'h3aff, 14'h200a, 14'h280c, 14'h375a, 14'h0000, 14'h0063, 14'h0064,
    14'h2010, 14'h0009, 14'h0008};
  logic clk;
  logic nrst;
  logic [MID_IW-1:0] instr_word;
  logic [7:0] reg_rdata;
  logic [MID_AW-1:0] stack_head;
  mid_ctl_t ctl;
  logic [7:0] accum;
  mid_flags_t flags;
  int mismatches;
  int checked;
  int cycles = 0;
  logic [31:0] lfsr_q;
  logic [MID_IW-1:0] m_ir;
  bit m_valid;
  logic [MID_AW-1:0] m_fa;
  logic [7:0] m_acc;
  mid_flags_t m_fl;
  logic [7:0] m_reg [128];
  logic [MID_AW-1:0] m_stk [8];
  logic [2:0] m_sp;
  int m_f;

  mid_decoder i_mid_decoder (.clk(clk), .nrst(nrst), .instr_word(instr_word),
    .reg_rdata(reg_rdata), .stack_head(stack_head), .ctl(ctl), .accum(accum), .flags(flags));
  mid_mem i_mid_mem (.clk(clk), .ctl(ctl), .instr_word(instr_word), .reg_rdata(reg_rdata),
    .stack_head(stack_head));

  // 200 MHz core clock
  initial clk = 1'b0;
  always #2.5 clk = ~clk;

  // Hang guard, sized well past both runs
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 14000) begin
      mismatches = mismatches + 1;
      complete_run();
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  // Adder with both carries; subtract is passed as inverted operand plus one
  function automatic logic [7:0] add_op(input logic [7:0] x, input logic [7:0] y, input logic ci);
    int s;
    s = x + y + ci;
    m_fl[4] = s > 255;
    m_fl[3] = x[3:0] + y[3:0] + ci > 15;
    return s[7:0];
  endfunction

  task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_flags(input mid_flags_t got, input mid_flags_t exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t flags got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One instruction cycle of the model: execute the held word, then fetch
  task automatic model_step();
    logic [13:0] w;
    logic [7:0] r;
    logic [7:0] k;
    logic [7:0] res;
    bit br;
    bit pop;
    bit sk;
    bit z;
    int dst;
    logic [MID_AW-1:0] tgt;
    w = m_ir;
    k = w[7:0];
    m_f = w[6:0];
    r = m_reg[m_f];
    res = r;
    br = 0;
    pop = 0;
    sk = 0;
    z = 0;
    dst = 0;
    tgt = w[10:0];
    if (m_valid && w[13:12] == 2'b00) begin
      dst = (w[11:8] == 4'h0) ? w[7] : 1;
      z = ZMASK[w[11:8]];
      pop = w[11:1] == 11'h004;
      if (w[11:0] == 12'h064 || w[11:0] == 12'h063) m_fl[1:0] = {1'b1, k[2]};
      case (w[11:8])
        4'h0: res = m_acc;
        4'h1: res = 8'h00;
        4'h2: res = add_op(r, ~m_acc, 1'b1);
        4'h3, 4'hb: res = r - 8'h01;
        4'h4: res = r | m_acc;
        4'h5: res = r & m_acc;
        4'h6: res = r ^ m_acc;
        4'h7: res = add_op(r, m_acc, 1'b0);
        4'h9: res = ~r;
        4'ha, 4'hf: res = r + 8'h01;
        4'hc: res = {m_fl[4], r[7:1]};
        4'hd: res = {r[6:0], m_fl[4]};
        4'he: res = {r[3:0], r[7:4]};
        default: res = r;
      endcase
      if (w[11:9] == 3'b110) m_fl[4] = w[8] ? r[7] : r[0];
      sk = (w[11:8] == 4'hb || w[11:8] == 4'hf) && res == 8'h00;
    end else if (m_valid && w[13:12] == 2'b01) begin
      res[w[9:7]] = w[10];
      sk = w[11] && r[w[9:7]] == w[10];
      dst = w[11] ? 0 : 3;
    end else if (m_valid && w[13:12] == 2'b10) begin
      br = 1;
      if (!w[11]) m_stk[m_sp] = m_fa;
      if (!w[11]) m_sp = m_sp + 3'h1;
    end else if (m_valid) begin
      dst = (w[11:8] == 4'hb) ? 0 : 2;
      z = w[11] && w[11:8] != 4'hb;
      pop = w[11:10] == 2'b01;
      casez (w[11:8])
        4'b0???: res = k;
        4'h8: res = m_acc | k;
        4'h9: res = m_acc & k;
        4'ha: res = m_acc ^ k;
        4'b110?: res = add_op(k, ~m_acc, 1'b1);
        4'b111?: res = add_op(k, m_acc, 1'b0);
        default: res = m_acc;
      endcase
    end
    if (pop) m_sp = m_sp - 3'h1;
    if (pop) tgt = m_stk[m_sp];
    if (z) m_fl[2] = res == 8'h00;
    if (dst == 3 || (dst == 1 && w[7])) m_reg[m_f] = res;
    else if (dst != 0) m_acc = res;
    m_valid = !(br || pop || sk);
    m_ir = i_mid_mem.prog[m_fa];
    m_fa = (br || pop) ? tgt : m_fa + 11'h001;
  endtask

  // Reset, load memories from the generator, then step and compare per cycle
  task automatic run_test(input string name, input int n, input bit dir);
    nrst <= 1'b0;
    for (int i = 0; i < 2048; i++) begin
      lfsr_q = lfsr(lfsr_q);
      i_mid_mem.prog[i] = (dir && i < 17) ? DIR_PROG[i] : lfsr_q[13:0];
      if (i < 128) m_reg[i] = lfsr_q[21:14];
      if (i < 128) i_mid_mem.regs[i] = lfsr_q[21:14];
      if (i < 8) m_stk[i] = lfsr_q[31:21];
      if (i < 8) i_mid_mem.stk[i] = lfsr_q[31:21];
    end
    repeat (20) @(posedge clk);
    i_mid_mem.sp = 3'h0;
    m_sp = 3'h0;
    m_fa = 11'h000;
    m_valid = 1'b0;
    m_acc = 8'h00;
    m_fl = 5'h03;
    m_ir = 14'h0000;
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      model_step();
      repeat (2) @(posedge clk);
      #1;
      cmp_val(16'(accum), 16'(m_acc));
      cmp_flags(flags, m_fl);
      cmp_val(16'(ctl.fetch_pointer), 16'(m_fa));
      cmp_val(16'(i_mid_mem.regs[m_f]), 16'(m_reg[m_f]));
      repeat (2) @(posedge clk);
    end
    $display("test %s done", name);
  endtask

  task automatic complete_run();
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Directed skips and branches first, then random words after a mid-run reset
  initial begin
    nrst = 1'b0;
    mismatches = 0;
    checked = 0;
    lfsr_q = 32'h3d04;
    run_test("directed", 40, 1'b1);
    run_test("random", 2500, 1'b0);
    complete_run();
  end
endmodule
`default_nettype wire
